// [safety_guard_pkg.sv]
// Package: register map, field positions, reset values and CRC constants
package safety_guard_pkg;

  // AXI address width: printed offsets are word indexes, byte address = 4x
  localparam int          ADDR_W         = 34;
  localparam logic [31:0] IDX_PARITY_CTL = 32'h40020425;
  localparam logic [31:0] IDX_CRC_REM    = 32'h400432fa;
  localparam logic [31:0] IDX_CRC_IN     = 32'h400433ac;
  localparam logic [31:0] IDX_GUARD      = 32'h40040478;
  localparam logic [ADDR_W-1:0] ADDR_PARITY_CTL = {IDX_PARITY_CTL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CRC_REM    = {IDX_CRC_REM, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CRC_IN     = {IDX_CRC_IN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GUARD      = {IDX_GUARD, 2'b00};

  // Reset values
  localparam logic [7:0]  RST_PARITY_CTL = 8'h00;
  localparam logic [15:0] RST_CRC_REM    = 16'h0000;
  localparam logic [7:0]  RST_CRC_IN     = 8'h00;
  localparam logic [7:0]  RST_GUARD      = 8'h00;

  // Field positions
  localparam int POS_PARITY_FLAG = 0;
  localparam int POS_PARITY_MASK = 7;
  localparam int POS_GUARD_CLOCK = 0;
  localparam int POS_GUARD_INT   = 1;
  localparam int POS_GUARD_PORT  = 2;
  localparam int GUARD_BITS      = 3;

  // CCITT x^16+x^12+x^5+1, bit-reversed for LSB-first shifting
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [safety_crc_parity_guard.sv]
// Safety block: general CRC-16 engine, RAM parity guard, register write guard
module safety_crc_parity_guard #(
  parameter int RAM_AW    = 8,
  parameter int RAM_DEPTH = 256
) (
  // Clock and reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // AXI4-Lite write address
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [safety_guard_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                           s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  // AXI4-Lite write response
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  output logic [1:0]                                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  input  wire logic [safety_guard_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                           s_axi_arprot,
  // AXI4-Lite read data
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  // Protected RAM port
  input  wire logic [3:0]                           ram_we,
  input  wire logic                                 ram_re,
  input  wire logic [RAM_AW-1:0]                    ram_addr,
  input  wire logic [31:0]                          ram_wdata,
  input  wire logic [3:0]                           ram_par_flip,
  output logic [31:0]                               ram_rdata,
  output logic                                      ram_rvalid,
  // Reset unit
  output logic                                      parity_reset_req,
  output logic                                      parity_reset_cause,
  // Write-guard levels to the guarded register groups
  output logic                                      guard_port_group,
  output logic                                      guard_interrupt_group,
  output logic                                      guard_clock_group
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // One byte through the LSB-first CCITT shift register
  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0]  d);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ d[i];
      c  = {1'b0, c[15:1]};
      if (fb) begin
        c = c ^ safety_guard_pkg::CRC_POLY_REFL;
      end
    end
    return c;
  endfunction

  function automatic logic reg_mapped(
    input logic [safety_guard_pkg::ADDR_W-1:0] a);
    return a == safety_guard_pkg::ADDR_PARITY_CTL ||
           a == safety_guard_pkg::ADDR_CRC_REM ||
           a == safety_guard_pkg::ADDR_CRC_IN ||
           a == safety_guard_pkg::ADDR_GUARD;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data held independently

  logic                                aw_held;
  logic [safety_guard_pkg::ADDR_W-1:0] aw_addr_q;
  logic                                w_held;
  logic [31:0]                         w_data_q;
  logic [3:0]                          w_strb_q;
  logic                                bvalid_q;
  logic [1:0]                          bresp_q;

  wire wr_go = aw_held & w_held & ~bvalid_q;

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held   <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held   <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held   <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= safety_guard_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= reg_mapped(aw_addr_q) ? safety_guard_pkg::RESP_OKAY
                                        : safety_guard_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode

  logic [7:0]  guard;
  logic [15:0] crc_rem;
  logic [7:0]  crc_in;
  logic        crc_pend;
  logic        par_mask;
  logic        par_flag;

  wire hit_par   = aw_addr_q == safety_guard_pkg::ADDR_PARITY_CTL;
  wire hit_rem   = aw_addr_q == safety_guard_pkg::ADDR_CRC_REM;
  wire hit_in    = aw_addr_q == safety_guard_pkg::ADDR_CRC_IN;
  wire hit_guard = aw_addr_q == safety_guard_pkg::ADDR_GUARD;

  // A guarded write still answers OKAY; it simply has no effect
  wire wr_par    = wr_go & hit_par & w_strb_q[0] &
                   ~guard[safety_guard_pkg::POS_GUARD_CLOCK];
  wire wr_rem    = wr_go & hit_rem & (|w_strb_q[1:0]);
  wire wr_in     = wr_go & hit_in & w_strb_q[0];
  wire wr_guard  = wr_go & hit_guard & w_strb_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Write guard

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      guard <= safety_guard_pkg::RST_GUARD;
    end else if (wr_guard) begin
      guard <= {5'h00, w_data_q[2:0]};
    end
  end

  // Port guard is meant for mode/config registers only, never output data
  assign guard_port_group = guard[safety_guard_pkg::POS_GUARD_PORT];
  assign guard_interrupt_group = guard[safety_guard_pkg::POS_GUARD_INT];
  assign guard_clock_group     = guard[safety_guard_pkg::POS_GUARD_CLOCK];

  ////////////////////////////////////////////////////////////////////////////
  // General CRC engine: byte taken, result stored on the next edge

  wire [15:0] crc_next_val = crc_byte(crc_rem, crc_in);
  wire [15:0] rem_wr_val   = {w_strb_q[1] ? w_data_q[15:8] : crc_rem[15:8],
                              w_strb_q[0] ? w_data_q[7:0]  : crc_rem[7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_in   <= safety_guard_pkg::RST_CRC_IN;
      crc_pend <= 1'b0;
    end else begin
      crc_pend <= wr_in;
      if (wr_in) begin
        crc_in <= w_data_q[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_rem <= safety_guard_pkg::RST_CRC_REM;
    end else if (crc_pend) begin
      crc_rem <= crc_next_val;
    end else if (wr_rem) begin
      crc_rem <= rem_wr_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protected RAM: 8 data bits plus one parity bit per lane

  logic [31:0] mem_word;
  logic [3:0]  mem_par;
  logic [3:0]  rd_par_q;
  logic [3:0]  calc_par;

  // Only this array carries parity; nothing outside it is checked
  for (genvar g = 0; g < 4; g++) begin : g_lane
    logic [7:0] lane_mem [RAM_DEPTH];
    logic       lane_par [RAM_DEPTH];
    always_ff @(posedge aclk) begin
      if (ram_we[g]) begin
        lane_mem[ram_addr] <= ram_wdata[8*g +: 8];
        lane_par[ram_addr] <= (^ram_wdata[8*g +: 8]) ^
                              ram_par_flip[g];
      end
    end
    assign mem_word[8*g +: 8] = lane_mem[ram_addr];
    assign mem_par[g]         = lane_par[ram_addr];
    assign calc_par[g] = ^ram_rdata[8*g +: 8];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_rvalid <= 1'b0;
      ram_rdata  <= '0;
      rd_par_q   <= '0;
    end else begin
      ram_rvalid <= ram_re;
      if (ram_re) begin
        ram_rdata <= mem_word;
        rd_par_q  <= mem_par;
      end
    end
  end

  wire par_err = ram_rvalid & (|(calc_par ^ rd_par_q));

  ////////////////////////////////////////////////////////////////////////////
  // Parity control: sticky flag, reset mask, reset request

  wire clr_flag   = wr_par & ~w_data_q[safety_guard_pkg::POS_PARITY_FLAG];
  // Set wins over a clear landing in the same cycle
  wire next_flag  = par_err | (par_flag & ~clr_flag);
  wire next_mask  = wr_par ? w_data_q[safety_guard_pkg::POS_PARITY_MASK]
                           : par_mask;
  wire next_req   = (par_err & ~next_mask) |
                    (par_mask & ~next_mask & par_flag);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par_flag <= safety_guard_pkg::RST_PARITY_CTL[
                    safety_guard_pkg::POS_PARITY_FLAG];
      par_mask <= safety_guard_pkg::RST_PARITY_CTL[
                    safety_guard_pkg::POS_PARITY_MASK];
    end else begin
      par_flag <= next_flag;
      par_mask <= next_mask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parity_reset_req   <= 1'b0;
      parity_reset_cause <= 1'b0;
    end else begin
      parity_reset_req <= next_req;
      if (next_req) begin
        parity_reset_cause <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: one cycle from address to data

  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire [31:0] rd_mux =
    (s_axi_araddr == safety_guard_pkg::ADDR_PARITY_CTL) ?
      {24'h000000, par_mask, 6'h00, par_flag} :
    (s_axi_araddr == safety_guard_pkg::ADDR_CRC_REM) ?
      {16'h0000, crc_rem} :
    (s_axi_araddr == safety_guard_pkg::ADDR_CRC_IN) ?
      {24'h000000, crc_in} :
    (s_axi_araddr == safety_guard_pkg::ADDR_GUARD) ?
      {24'h000000, guard} : 32'h00000000;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= safety_guard_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= reg_mapped(s_axi_araddr) ? safety_guard_pkg::RESP_OKAY
                                           : safety_guard_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_byte_write;
    wr_in ##1 crc_pend;
  endsequence

  a_crc_one_clock: assert property (
    s_byte_write |=> crc_rem == crc_byte($past(crc_rem), $past(crc_in)))
    else $error("CRC result not stored one clock after byte");

  a_crc_preset_drop: assert property (
    crc_pend && wr_rem |=> crc_rem == $past(crc_next_val))
    else $error("Remainder write won over CRC store");

  a_crc_preset_take: assert property (
    wr_rem && !crc_pend |=> crc_rem == $past(rem_wr_val))
    else $error("Remainder preset not taken");

  a_guard_reads_zero: assert property (
    guard[7:3] == 5'h00)
    else $error("Guard upper bits not zero");

  a_guard_blocks_par: assert property (
    wr_go && hit_par && guard_clock_group |=>
      par_mask == $past(par_mask))
    else $error("Guarded parity control write took effect");

  a_flag_sticky: assert property (
    par_flag && !clr_flag |=> par_flag)
    else $error("Parity flag dropped without clear");

  a_flag_sets: assert property (
    par_err |=> par_flag)
    else $error("Parity error did not set flag");

  sequence s_unmask_with_flag;
    par_flag && par_mask && wr_par &&
      !w_data_q[safety_guard_pkg::POS_PARITY_MASK];
  endsequence

  a_unmask_resets: assert property (
    s_unmask_with_flag |=> parity_reset_req ##1 parity_reset_cause)
    else $error("Unmask with flag set did not reset");

  a_masked_no_reset: assert property (
    par_mask && !wr_par |=> !parity_reset_req)
    else $error("Reset requested while masked");

  a_err_resets: assert property (
    par_err && !next_mask |=> parity_reset_req)
    else $error("Unmasked parity error gave no reset");

  a_read_one_cycle: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid [*1])
    else $error("Read answer late");

endmodule

// [axi_lite_master.sv]
// AXI4-Lite master model standing in for the CPU or DMA controller
module axi_lite_master (
  // Clock
  input  wire logic                                aclk,
  // Write address and data
  output logic                                     awvalid,
  input  wire logic                                awready,
  output logic [safety_guard_pkg::ADDR_W-1:0]      awaddr,
  output logic [2:0]                               awprot,
  output logic                                     wvalid,
  input  wire logic                                wready,
  output logic [31:0]                              wdata,
  output logic [3:0]                               wstrb,
  // Write response
  input  wire logic                                bvalid,
  output logic                                     bready,
  input  wire logic [1:0]                          bresp,
  // Read
  output logic                                     arvalid,
  input  wire logic                                arready,
  output logic [safety_guard_pkg::ADDR_W-1:0]      araddr,
  output logic [2:0]                               arprot,
  input  wire logic                                rvalid,
  output logic                                     rready,
  input  wire logic [31:0]                         rdata,
  input  wire logic [1:0]                          rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, awprot, arprot} = '0;
    wstrb  = 4'hf;
    // Held up for good: the answer is taken whenever it comes
    bready = 1'b1;
    rready = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Both tasks start just after a rising edge and return just after one
  task automatic wr(input logic [safety_guard_pkg::ADDR_W-1:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      // Readies move only at rising edges, so the falling edge sees them
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid;
      resp  = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [safety_guard_pkg::ADDR_W-1:0] a,
                    output logic [31:0] d, output logic [1:0] resp);
    logic ar_hs;
    logic r_hs;
    araddr  <= a;
    arvalid <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs  = rvalid;
      d     = rdata;
      resp  = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
  endtask
endmodule

// [safety_crc_parity_guard_test.sv]
// Self-checking bench for CRC engine, RAM parity guard and write guard
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %s exp %0h got %0h", what, exp, got); \
    end \
  end

module safety_crc_parity_guard_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = safety_guard_pkg::ADDR_W;

  logic          aclk = 1'b0;
  logic          aresetn;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready, ram_re, ram_rvalid;
  logic          parity_reset_req, parity_reset_cause;
  logic          guard_port_group, guard_interrupt_group, guard_clock_group;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0]   wdata, rdata, ram_wdata, ram_rdata, rdat;
  logic [7:0]    ram_addr;
  logic [3:0]    wstrb, ram_we, ram_par_flip;
  logic [2:0]    awprot, arprot, guards;
  logic [1:0]    bresp, rresp, resp;
  int            fails = 0;
  int            n_checks = 0;
  int            n_req = 0;

  assign guards = {guard_port_group, guard_interrupt_group, guard_clock_group};

  safety_crc_parity_guard i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_par_flip(ram_par_flip),
    .ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid),
    .parity_reset_req(parity_reset_req),
    .parity_reset_cause(parity_reset_cause),
    .guard_port_group(guard_port_group),
    .guard_interrupt_group(guard_interrupt_group),
    .guard_clock_group(guard_clock_group)
  );

  axi_lite_master i_master (
    .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp)
  );

  always #5 aclk = ~aclk;

  // Each request is one cycle high, so every high sample is one request
  always @(posedge aclk)
    if (parity_reset_req === 1'b1) n_req++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_wr(input logic [AW-1:0] a, input logic [31:0] d);
    i_master.wr(a, d, 4'hf, resp);
  endtask

  task automatic reg_chk(input logic [AW-1:0] a, input logic [31:0] exp,
                         input string what);
    i_master.rd(a, rdat, resp);
    `CHK(what, exp, rdat)
    `CHK("read response", safety_guard_pkg::RESP_OKAY, resp)
  endtask

  task automatic guard_chk(input logic [2:0] exp);
    // Guards update on the response edge; look once they have settled
    @(negedge aclk);
    `CHK("guard levels", exp, guards)
    @(posedge aclk);
  endtask

  function automatic logic [15:0] crc_ref(logic [15:0] c, logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    return c;
  endfunction

  task automatic ram_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] flip);
    ram_we       <= 4'hf;
    ram_addr     <= a;
    ram_wdata    <= d;
    ram_par_flip <= flip;
    @(posedge aclk);
    ram_we       <= 4'h0;
    ram_par_flip <= 4'h0;
    @(posedge aclk);
  endtask

  task automatic ram_rd(input logic [7:0] a, input logic [31:0] exp);
    ram_re   <= 1'b1;
    ram_addr <= a;
    @(posedge aclk);
    ram_re <= 1'b0;
    @(negedge aclk);
    `CHK("ram read valid", 1'b1, ram_rvalid)
    `CHK("ram read data", exp, ram_rdata)
    repeat (3) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    reg_chk(safety_guard_pkg::ADDR_CRC_REM, 32'h0, "crc_remainder");
    reg_chk(safety_guard_pkg::ADDR_CRC_IN, 32'h0, "crc_byte_input");
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h0, "parity_ctl");
    reg_chk(safety_guard_pkg::ADDR_GUARD, 32'h0, "guard reg");
    `CHK("guard levels", 3'b000, guards)
    `CHK("reset cause", 1'b0, parity_reset_cause)
    i_master.rd(safety_guard_pkg::ADDR_GUARD + 34'h4, rdat, resp);
    `CHK("unmapped response", safety_guard_pkg::RESP_SLVERR, resp)
  endtask

  task automatic t_crc();
    logic [15:0] c;
    logic [7:0]  b [6] = '{8'h78, 8'h56, 8'h34, 8'h12, 8'hff, 8'h00};
    c = 16'h0000;
    reg_wr(safety_guard_pkg::ADDR_CRC_REM, 32'h0);
    foreach (b[i]) begin
      reg_wr(safety_guard_pkg::ADDR_CRC_IN, {24'h0, b[i]});
      c = crc_ref(c, b[i]);
      // Read straight after the response: one core clock is all it gets
      reg_chk(safety_guard_pkg::ADDR_CRC_REM, {16'h0, c}, "rem");
      reg_chk(safety_guard_pkg::ADDR_CRC_IN, {24'h0, b[i]}, "in");
      if (i == 3) reg_chk(safety_guard_pkg::ADDR_CRC_REM, 32'h08f6, "ref");
    end
  endtask

  task automatic t_preset();
    reg_wr(safety_guard_pkg::ADDR_CRC_REM, 32'h0000a5c3);
    reg_chk(safety_guard_pkg::ADDR_CRC_REM, 32'h0000a5c3, "preset");
    // High lane only: the low byte of the preset must survive
    i_master.wr(safety_guard_pkg::ADDR_CRC_REM, 32'h00007e00, 4'h2, resp);
    reg_chk(safety_guard_pkg::ADDR_CRC_REM, 32'h00007ec3, "lane");
    reg_wr(safety_guard_pkg::ADDR_CRC_IN, 32'h0000005a);
    reg_chk(safety_guard_pkg::ADDR_CRC_REM, {16'h0, crc_ref(16'h7ec3, 8'h5a)},
            "preset chain");
  endtask

  task automatic t_parity();
    int base;
    base = n_req;
    ram_wr(8'h10, 32'h12345678, 4'h0);
    ram_wr(8'h11, 32'h0f0f00ff, 4'h4);
    ram_rd(8'h10, 32'h12345678);
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h0, "clean flag");
    ram_rd(8'h11, 32'h0f0f00ff);
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h1, "err flag");
    `CHK("one request", base + 1, n_req)
    `CHK("reset cause", 1'b1, parity_reset_cause)
    ram_rd(8'h10, 32'h12345678);
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h1, "sticky");
    reg_wr(safety_guard_pkg::ADDR_PARITY_CTL, 32'h80);
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h80, "cleared");
    ram_rd(8'h11, 32'h0f0f00ff);
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h81, "masked");
    `CHK("masked request", base + 1, n_req)
    reg_wr(safety_guard_pkg::ADDR_PARITY_CTL, 32'h01);
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h01, "unmask");
    `CHK("unmask request", base + 2, n_req)
    reg_wr(safety_guard_pkg::ADDR_PARITY_CTL, 32'h00);
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h0, "flag clr");
  endtask

  task automatic t_guard();
    for (int i = 0; i < 3; i++) begin
      reg_wr(safety_guard_pkg::ADDR_GUARD, 32'h1 << i);
      guard_chk(3'b001 << i);
    end
    reg_wr(safety_guard_pkg::ADDR_GUARD, 32'hff);
    guard_chk(3'b111);
    reg_chk(safety_guard_pkg::ADDR_GUARD, 32'h07, "guard bits");
    reg_wr(safety_guard_pkg::ADDR_PARITY_CTL, 32'h80);
    `CHK("guarded response", safety_guard_pkg::RESP_OKAY, resp)
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h0, "guarded");
    reg_wr(safety_guard_pkg::ADDR_GUARD, 32'h06);
    reg_wr(safety_guard_pkg::ADDR_PARITY_CTL, 32'h80);
    reg_chk(safety_guard_pkg::ADDR_PARITY_CTL, 32'h80, "open");
  endtask

  // Reset in mid-run with state loaded in every register but the parity flag
  task automatic t_rst2();
    reg_wr(safety_guard_pkg::ADDR_CRC_REM, 32'h00001357);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
  endtask

  task automatic summarize();
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {ram_we, ram_re, ram_addr, ram_wdata, ram_par_flip} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_crc();
    t_preset();
    t_parity();
    t_guard();
    t_rst2();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize();
  end
endmodule
